// ---- src/pool_map.svh ----
// Offsets, field positions, reset values and timing counts of the pool.
// Assumes a 125 MHz pclk and 32-bit APB word addressing.
`ifndef POOL_MAP_SVH
`define POOL_MAP_SVH

`define POOL_CLK_HZ        125000000
`define POOL_NRES          12
// Register byte offsets
`define REG_CTRL           12'h000
`define REG_CODE           12'h004
`define REG_CMD            12'h008
`define REG_RESULT         12'h00C
`define REG_IRQ_STAT       12'h010
`define REG_IRQ_MASK       12'h014
`define REG_STATE_LO       12'h018
`define REG_STATE_HI       12'h01C
`define REG_LINK_SEL       12'h020
`define REG_LINK_STAT      12'h024
// Control option bits
`define CTRL_LOOP_DSR      0
`define CTRL_CARR_DISC     1
`define CTRL_CTS_CARR      2
`define CTRL_SPACE_DISC    3
`define CTRL_SEND_SPACE    4
`define CTRL_PERMIT_MM     5
`define CTRL_RESET         6'h1F
`define CODE_RESET         14'd820
`define CODE_MAX           14'd9999
// Command field positions
`define CMD_OP_LSB         0
`define CMD_RES_LSB        4
`define CMD_ARG_LSB        8
// Interrupt bits
`define IRQ_NORES          0
`define IRQ_CLASH          1
`define IRQ_TIMEOUT        2
`define IRQ_DISC           3
`define IRQ_REJ            4
// Timing, in milliseconds; MS_CYCLES is pclk cycles per millisecond
`define HANDSHAKE_MS       15000
`define SPACE_RX_MS        2000
`define SPACE_TX_MS        4000
`define CTS_DELAY_MS       10
`define MS_CYCLES          (`POOL_CLK_HZ / 1000)

`endif

// ---- src/pool_pkg.sv ----
// Types shared by the modem pool allocator and its bench.
// Assumes nothing of its surroundings.
package pool_pkg;
  typedef enum logic [1:0] {RES_FREE, RES_RESERVED, RES_SEIZED} res_state_t;
  typedef enum logic [3:0] {
    OP_NONE, OP_REQUEST, OP_CONNECT, OP_RELEASE, OP_INTERCEPT, OP_QUEUED
  } op_t;
  typedef enum logic [1:0] {RATE_300, RATE_1200, RATE_OTHER} rate_t;
endpackage

// ---- src/modem_channel.sv ----
// Supervises one seized conversion resource: handshake timeout, carrier,
// clear-to-send and received/sent space handling.
// Assumes modem pins are already synchronised and a 1 ms tick enable.
`include "pool_map.svh"

module modem_channel (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tick_ms,
  input  wire logic active,
  input  wire logic [5:0] opts,
  input  wire logic loop_test,
  input  wire logic carrier,
  input  wire logic rx_space,
  input  wire logic dtr,
  input  wire logic handshake_ok,
  output logic      dsr,
  output logic      cts,
  output logic      cd,
  output logic      tx_space,
  output logic      timeout,
  output logic      disc
);
  logic [13:0] hs_ms;
  logic [11:0] sp_ms;
  logic [11:0] tx_ms;
  logic [4:0]  cts_ms;
  logic        hs_done;
  logic        carr_seen;
  logic        dtr_seen;

  // ----------------------------------------------------------------
  // Handshake supervision
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_ms   <= '0;
      hs_done <= 1'b0;
      timeout <= 1'b0;
    end else begin
      timeout <= 1'b0;
      if (!active) begin
        hs_ms   <= '0;
        hs_done <= 1'b0;
      end else if (handshake_ok) begin
        hs_done <= 1'b1;
      end else if (!hs_done && tick_ms) begin
        if (hs_ms == 14'(`HANDSHAKE_MS - 1)) begin
          timeout <= 1'b1;
          hs_done <= 1'b1;
        end
        hs_ms <= hs_ms + 14'd1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Carrier, clear-to-send and data-set-ready
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_ms    <= '0;
      carr_seen <= 1'b0;
      cd        <= 1'b0;
      cts       <= 1'b0;
      dsr       <= 1'b0;
    end else begin
      dsr <= active && (!loop_test || opts[`CTRL_LOOP_DSR]);
      if (!active) begin
        cts_ms    <= '0;
        carr_seen <= 1'b0;
        cd        <= 1'b0;
        cts       <= 1'b0;
      end else if (opts[`CTRL_CTS_CARR]) begin
        // Neither rises before carrier and the delay have both passed
        if (!carrier) begin
          cd  <= 1'b0;
          cts <= 1'b0;
        end else if (!carr_seen) begin
          if (tick_ms) cts_ms <= cts_ms + 5'd1;
          if (cts_ms == 5'(`CTS_DELAY_MS)) begin
            carr_seen <= 1'b1;
            cd        <= 1'b1;
            cts       <= 1'b1;
          end
        end else begin
          cd  <= 1'b1;
          cts <= 1'b1;
        end
      end else begin
        cd  <= carrier;
        cts <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Space detection, space on disconnect, disconnect request
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_ms    <= '0;
      tx_ms    <= '0;
      tx_space <= 1'b0;
      dtr_seen <= 1'b0;
      disc     <= 1'b0;
    end else begin
      disc <= 1'b0;
      if (!active) begin
        sp_ms    <= '0;
        tx_ms    <= '0;
        tx_space <= 1'b0;
        dtr_seen <= 1'b0;
      end else begin
        if (dtr) dtr_seen <= 1'b1;
        if (!rx_space) sp_ms <= '0;
        else if (tick_ms) sp_ms <= sp_ms + 12'd1;
        if (opts[`CTRL_SPACE_DISC] && sp_ms == 12'(`SPACE_RX_MS))
          disc <= 1'b1;
        if (opts[`CTRL_CARR_DISC] && cd == 1'b1 && !carrier)
          disc <= 1'b1;
        if (dtr_seen && !dtr && !tx_space) begin
          if (opts[`CTRL_SEND_SPACE]) tx_space <= 1'b1;
          else disc <= 1'b1;
        end
        if (tx_space && tick_ms) begin
          tx_ms <= tx_ms + 12'd1;
          if (tx_ms == 12'(`SPACE_TX_MS - 1)) disc <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- src/modem_pool_allocator.sv ----
// Modem pool allocator: reservation, option check, seizure and release of
// up to twelve pooled conversion resources, with APB registers.
// Assumes call processing issues commands over APB and modem pins are async.
//
// The APB register port and the placing of the registers were decided locally.
`include "pool_map.svh"

module modem_pool_allocator (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  input  wire logic [11:0] loop_test_pin,
  input  wire logic [11:0] carrier_pin,
  input  wire logic [11:0] rx_space_pin,
  input  wire logic [11:0] dtr_pin,
  input  wire logic [11:0] handshake_pin,
  output logic      [11:0] dsr,
  output logic      [11:0] cts,
  output logic      [11:0] cd,
  output logic      [11:0] tx_space,
  output logic      [11:0] in_path,
  output logic      [11:0] hangup
);
  localparam int N = `POOL_NRES;

  logic [5:0]  ctrl;
  logic [13:0] code;
  logic [31:0] result;
  logic [4:0]  irq_stat;
  logic [4:0]  irq_mask;
  logic [3:0]  link_sel;
  pool_pkg::res_state_t rstate [N];
  logic [4:0]  ev;
  logic        wr;
  logic        rd;
  logic [16:0] ms_div;
  logic        tick_ms;
  logic [11:0] sync1 [5];
  logic [11:0] sync2 [5];
  logic [11:0] timeout_v;
  logic [11:0] disc_v;
  logic [11:0] act_v;
  logic [3:0]  free_idx;
  logic        free_any;
  logic        addr_ok;

  assign wr      = psel && penable && pwrite;
  assign rd      = psel && !pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign irq     = |(irq_stat & irq_mask);

  always_comb begin
    unique case (paddr)
      `REG_CTRL, `REG_CODE, `REG_CMD, `REG_RESULT, `REG_IRQ_STAT,
      `REG_IRQ_MASK, `REG_STATE_LO, `REG_STATE_HI, `REG_LINK_SEL,
      `REG_LINK_STAT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Millisecond tick and pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_div  <= '0;
      tick_ms <= 1'b0;
    end else begin
      tick_ms <= (ms_div == 17'(`MS_CYCLES - 1));
      ms_div  <= (ms_div == 17'(`MS_CYCLES - 1)) ? '0 : ms_div + 17'd1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < 5; k++) begin
        sync1[k] <= '0;
        sync2[k] <= '0;
      end
    end else begin
      sync1[0] <= loop_test_pin;
      sync1[1] <= carrier_pin;
      sync1[2] <= rx_space_pin;
      sync1[3] <= dtr_pin;
      sync1[4] <= handshake_pin;
      for (int k = 0; k < 5; k++) sync2[k] <= sync1[k];
    end
  end

  // ----------------------------------------------------------------
  // Per-resource supervisors
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : ch
      assign act_v[g] = (rstate[g] == pool_pkg::RES_SEIZED);
      modem_channel u_ch (
        .pclk         (pclk),
        .presetn      (presetn),
        .tick_ms      (tick_ms),
        .active       (act_v[g]),
        .opts         (ctrl),
        .loop_test    (sync2[0][g]),
        .carrier      (sync2[1][g]),
        .rx_space     (sync2[2][g]),
        .dtr          (sync2[3][g]),
        .handshake_ok (sync2[4][g]),
        .dsr          (dsr[g]),
        .cts          (cts[g]),
        .cd           (cd[g]),
        .tx_space     (tx_space[g]),
        .timeout      (timeout_v[g]),
        .disc         (disc_v[g])
      );
    end
  endgenerate

  assign in_path = act_v;

  // Lowest numbered free resource
  always_comb begin
    free_idx = '0;
    free_any = 1'b0;
    for (int k = N - 1; k >= 0; k--) begin
      if (rstate[k] == pool_pkg::RES_FREE) begin
        free_idx = 4'(k);
        free_any = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Option and request code registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= `CTRL_RESET;
      code     <= `CODE_RESET;
      irq_mask <= '0;
      link_sel <= '0;
    end else if (wr) begin
      if (paddr == `REG_CTRL) ctrl <= pwdata[5:0];
      if (paddr == `REG_CODE && pwdata[13:0] != '0
          && pwdata[13:0] <= `CODE_MAX)
        code <= pwdata[13:0];
      if (paddr == `REG_IRQ_MASK) irq_mask <= pwdata[4:0];
      if (paddr == `REG_LINK_SEL && pwdata[3:0] < 4'(N))
        link_sel <= pwdata[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Command decode and resource states
  // CMD: op[3:0], resource[7:4], argument[13:8]
  // Argument for REQUEST: bit8 digital end, bit9 analog end,
  //   bit10 DID/code-request, rate in bits [13:12]
  // ----------------------------------------------------------------
  logic [3:0]         op;
  logic [3:0]         cres;
  logic               need;
  pool_pkg::rate_t    crate;
  logic               rate_ok;
  assign op    = pwdata[`CMD_OP_LSB +: 4];
  assign cres  = pwdata[`CMD_RES_LSB +: 4];
  assign crate = pool_pkg::rate_t'(pwdata[13:12]);
  assign need  = (pwdata[8] && pwdata[9]) || pwdata[10];
  assign rate_ok = (crate == pool_pkg::RATE_300)
                || (crate == pool_pkg::RATE_1200) || ctrl[`CTRL_PERMIT_MM];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int k = 0; k < N; k++) rstate[k] <= pool_pkg::RES_FREE;
      result <= '0;
      ev     <= '0;
    end else begin
      ev <= '0;
      for (int k = 0; k < N; k++) begin
        if (rstate[k] == pool_pkg::RES_SEIZED && (timeout_v[k] || disc_v[k]))
          rstate[k] <= pool_pkg::RES_FREE;
      end
      ev[`IRQ_TIMEOUT] <= |timeout_v;
      ev[`IRQ_DISC]    <= |disc_v;
      if (wr && paddr == `REG_CMD) begin
        unique case (pool_pkg::op_t'(op))
          pool_pkg::OP_REQUEST: begin
            if (!need) begin
              result <= {16'h0000, 8'h00, 4'h0, 4'h0};
            end else if (!free_any) begin
              result <= {16'h0000, 8'h02, 4'h0, 4'h0};
              ev[`IRQ_NORES] <= 1'b1;
            end else if (!rate_ok) begin
              // Rate clash: nothing is reserved, resource never leaves free
              result <= {16'h0000, 8'h03, 4'h0, 4'h0};
              ev[`IRQ_CLASH] <= 1'b1;
            end else begin
              rstate[free_idx] <= pool_pkg::RES_RESERVED;
              result <= {16'h0000, 8'h01, 4'h0, free_idx};
            end
          end
          pool_pkg::OP_CONNECT, pool_pkg::OP_QUEUED: begin
            // Queued group calls seize only on digital completion; otherwise the reservation is freed
            if (cres < 4'(N) && rstate[cres] == pool_pkg::RES_RESERVED
                && (pool_pkg::op_t'(op) == pool_pkg::OP_CONNECT
                    || pwdata[8]))
              rstate[cres] <= pool_pkg::RES_SEIZED;
            else if (cres < 4'(N) && rstate[cres] == pool_pkg::RES_RESERVED)
              rstate[cres] <= pool_pkg::RES_FREE;
            else
              ev[`IRQ_REJ] <= 1'b1;
          end
          pool_pkg::OP_RELEASE, pool_pkg::OP_INTERCEPT: begin
            if (cres < 4'(N))
              rstate[cres] <= pool_pkg::RES_FREE;
            else
              ev[`IRQ_REJ] <= 1'b1;
          end
          default: ev[`IRQ_REJ] <= 1'b1;
        endcase
      end
    end
  end

  generate
    for (g = 0; g < N; g++) begin : hu
      assign hangup[g] = timeout_v[g] || disc_v[g];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Interrupt status: set wins over write-one-to-clear
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= '0;
    end else begin
      if (wr && paddr == `REG_IRQ_STAT)
        irq_stat <= (irq_stat & ~pwdata[4:0]) | ev;
      else
        irq_stat <= irq_stat | ev;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd && !penable) begin
      prdata <= '0;
      unique case (paddr)
        `REG_CTRL:      prdata <= {26'h0, ctrl};
        `REG_CODE:      prdata <= {18'h0, code};
        `REG_RESULT:    prdata <= result;
        `REG_IRQ_STAT:  prdata <= {27'h0, irq_stat};
        `REG_IRQ_MASK:  prdata <= {27'h0, irq_mask};
        `REG_STATE_LO:  prdata <= {20'h0, rstate[5], rstate[4], rstate[3],
                                   rstate[2], rstate[1], rstate[0]};
        `REG_STATE_HI:  prdata <= {20'h0, rstate[11], rstate[10], rstate[9],
                                   rstate[8], rstate[7], rstate[6]};
        `REG_LINK_SEL:  prdata <= {28'h0, link_sel};
        `REG_LINK_STAT: prdata <= {26'h0, tx_space[link_sel], cd[link_sel],
                                   cts[link_sel], dsr[link_sel],
                                   in_path[link_sel], hangup[link_sel]};
        default:        prdata <= '0;
      endcase
    end
  end
endmodule

// ---- tb/pool_sva.sv ----
// Port checker for the modem pool allocator.
// Assumes the register map and option bits of pool_map.svh.
`include "pool_map.svh"
module pool_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic [11:0] loop_test_pin,
  input wire logic [11:0] dtr_pin,
  input wire logic [11:0] dsr,
  input wire logic [11:0] cts,
  input wire logic [11:0] cd,
  input wire logic [11:0] tx_space,
  input wire logic [11:0] in_path,
  input wire logic [11:0] hangup
);
  // ----------------------------------------
  // Shadow of the written registers
  // ----------------------------------------
  logic [5:0]  ctrl;
  logic [13:0] code;
  logic [4:0]  mask;
  logic        mask_set;
  logic [11:0] lt1, lt2, lt3;
  wire acc = psel && penable && pready;
  wire wr  = acc && pwrite;
  wire rd  = acc && !pwrite;
  // Loop pin held long enough to cross the synchroniser
  wire [11:0] lt_ok = loop_test_pin & lt1 & lt2 & lt3 & in_path;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl     <= `CTRL_RESET;
      code     <= `CODE_RESET;
      mask     <= 5'h00;
      mask_set <= 1'b0;
    end else if (wr) begin
      if (paddr == `REG_CTRL) ctrl <= pwdata[5:0];
      if (paddr == `REG_CODE && pwdata[13:0] != 14'h0000
          && pwdata[13:0] <= `CODE_MAX) code <= pwdata[13:0];
      if (paddr == `REG_IRQ_MASK) begin
        mask     <= pwdata[4:0];
        mask_set <= 1'b1;
      end
    end
  end
  always_ff @(posedge pclk) begin
    lt1 <= loop_test_pin;
    lt2 <= lt1;
    lt3 <= lt2;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  code_read_a:
    assert property (rd && paddr == `REG_CODE |-> prdata[13:0] == code)
    else $error("code readback wrong");
  result_range_a:
    assert property (rd && paddr == `REG_RESULT && prdata[15:8] == 8'h01
      |-> prdata[3:0] < 4'hC) else $error("resource out of pool");
  seize_cause_a:
    assert property ((in_path & ~$past(in_path)) != 12'h000
      |-> $past(wr && paddr == `REG_CMD && (pwdata[3:0] == 4'h2
                || (pwdata[3:0] == 4'h5 && pwdata[8]))))
    else $error("seized without connect");
  loop_dsr_a:
    assert property (ctrl[`CTRL_LOOP_DSR] && $past(ctrl[`CTRL_LOOP_DSR], 4)
      |-> (dsr & lt_ok & $past(in_path)) == (lt_ok & $past(in_path)))
    else $error("no dsr in loop test");
  cts_carrier_a:
    assert property (ctrl[`CTRL_CTS_CARR]
      |-> (cts & ~cd & ~$past(cd)) == 12'h000)
    else $error("cts without carrier");
  tx_space_a:
    assert property (ctrl[`CTRL_SEND_SPACE]
      && (in_path & $past(dtr_pin) & ~dtr_pin) != 12'h000
      |-> ##[1:8] tx_space != 12'h000) else $error("no space sent");
  dtr_hangup_a:
    assert property (!ctrl[`CTRL_SEND_SPACE]
      && (in_path & $past(dtr_pin) & ~dtr_pin) != 12'h000
      |-> ##[1:8] hangup != 12'h000) else $error("no prompt hangup");
  unmapped_err_a:
    assert property (acc && paddr > `REG_LINK_STAT |-> pslverr)
    else $error("unmapped access not refused");
  mask_quiet_a:
    assert property (mask_set && mask == 5'h00 && $past(mask) == 5'h00
      |-> !irq) else $error("irq while all masked");
  req_c:  cover property (wr && paddr == `REG_CMD && pwdata[3:0] == 4'h1);
  full_c: cover property (rd && paddr == `REG_RESULT
                          && prdata[15:8] == 8'h02);
  err_c:  cover property (acc && pslverr);
endmodule
bind modem_pool_allocator pool_sva u_sva (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq), .loop_test_pin(loop_test_pin), .dtr_pin(dtr_pin), .dsr(dsr),
  .cts(cts), .cd(cd), .tx_space(tx_space), .in_path(in_path),
  .hangup(hangup));

// ---- tb/modem_chan_model.sv ----
// Behavioural pooled modem channels on the allocator's modem pins.
// Assumes in_path marks a seized channel; the bench commands faults.
module modem_chan_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] in_path,
  input  wire logic [11:0] drop_dtr,
  input  wire logic [11:0] loop_req,
  input  wire logic [7:0]  delay,
  output logic      [11:0] loop_test_pin,
  output logic      [11:0] carrier_pin,
  output logic      [11:0] rx_space_pin,
  output logic      [11:0] dtr_pin,
  output logic      [11:0] handshake_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Carrier and handshake after a set delay
  // ----------------------------------------
  logic [7:0] age [12];
  always_ff @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 12; i++) begin
      if (!presetn || !in_path[i]) age[i] <= 8'h00;
      else if (age[i] != 8'hFF) age[i] <= age[i] + 8'h01;
    end
  end
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      carrier_pin[i]   = in_path[i] && age[i] >= delay;
      handshake_pin[i] = carrier_pin[i];
    end
  end
  assign dtr_pin       = in_path & ~drop_dtr;
  assign loop_test_pin = loop_req;
  assign rx_space_pin  = 12'h000;
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the modem pool allocator over APB.
// Assumes the lowest free resource is reserved first.
`include "pool_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  typedef struct {logic [32:0] d; logic [32:0] m;} note_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr, in_path, hangup, dsr, cts, cd, tx_space;
  logic [11:0] lt, car, rxs, dtr, hs, drop_dtr, loop_req;
  logic [31:0] pwdata, prdata, lfsr;
  logic [7:0]  delay;
  logic [13:0] v;
  int          fail_count, num_checks, n;
  note_t       notes[$];
  note_t       t;
  modem_pool_allocator u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .loop_test_pin(lt), .carrier_pin(car), .rx_space_pin(rxs),
    .dtr_pin(dtr), .handshake_pin(hs), .dsr(dsr), .cts(cts), .cd(cd),
    .tx_space(tx_space), .in_path(in_path), .hangup(hangup));
  modem_chan_model u_far (.pclk(pclk), .presetn(presetn), .in_path(in_path),
    .drop_dtr(drop_dtr), .loop_req(loop_req), .delay(delay),
    .loop_test_pin(lt), .carrier_pin(car), .rx_space_pin(rxs),
    .dtr_pin(dtr), .handshake_pin(hs));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic flag(input logic got, input logic exp);
    check({32'h0, got}, {32'h0, exp});
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] d,
                    input logic [32:0] m = 33'h1FFFFFFFF);
    notes.push_back('{d, m});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input pool_pkg::op_t op, input logic [3:0] r,
                     input logic [1:0] rt, input logic [2:0] fl);
    apb(1'b1, `REG_CMD, {18'h0, rt, 1'b0, fl, r, op});
  endtask
  // Read results are compared as they complete on the bus
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (notes.size() == 0) check(33'h0, 33'h1FFFFFFFF);
      else begin
        t = notes.pop_front();
        check({pslverr, prdata} & t.m, t.d & t.m);
      end
    end
  end
  initial begin
    #100000;
    fail_count++;
    close_out();
  end
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; drop_dtr = 12'h000;
    loop_req = 12'h000; lfsr = 32'h10B4; delay = 8'h04;
    fail_count = 0; num_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`REG_CTRL, 33'h1F);
    rd(`REG_CODE, 33'h334);
    rd(`REG_STATE_LO, 33'h0);
    apb(1'b1, `REG_CODE, 32'h0);
    apb(1'b1, `REG_CODE, 32'h2710);
    rd(`REG_CODE, 33'h334);
    apb(1'b1, `REG_CODE, 32'h270F);
    rd(`REG_CODE, 33'h270F);
    lfsr = step(lfsr);
    v = 14'h0001 + {1'b0, lfsr[12:0]};
    apb(1'b1, `REG_CODE, {18'h0, v});
    rd(`REG_CODE, {19'h0, v});
    apb(1'b1, 12'h040, 32'hFFFFFFFF);
    rd(12'h040, 33'h100000000);
    apb(1'b1, `REG_IRQ_MASK, 32'h1F);
    cmd(pool_pkg::OP_REQUEST, 4'h0, 2'h0, 3'b001);
    rd(`REG_RESULT, 33'h0, 33'hFF00);
    for (int i = 0; i < 12; i++) begin
      lfsr = step(lfsr);
      cmd(pool_pkg::OP_REQUEST, 4'h0, {1'b0, lfsr[0]}, 3'b011);
      rd(`REG_RESULT, {25'h1, 4'h0, 4'(i)}, 33'hFF0F);
    end
    rd(`REG_STATE_LO, 33'h555, 33'hFFF);
    cmd(pool_pkg::OP_REQUEST, 4'h0, 2'h1, 3'b101);
    rd(`REG_RESULT, 33'h200, 33'hFF00);
    flag(irq, 1'b1);
    rd(`REG_IRQ_STAT, 33'h1, 33'h1);
    apb(1'b1, `REG_IRQ_STAT, 32'h1);
    flag(irq, 1'b0);
    cmd(pool_pkg::OP_RELEASE, 4'h3, 2'h0, 3'b000);
    cmd(pool_pkg::OP_REQUEST, 4'h0, 2'h2, 3'b011);
    rd(`REG_RESULT, 33'h300, 33'hFF00);
    rd(`REG_STATE_LO, 33'h515, 33'hFFF);
    apb(1'b1, `REG_CTRL, 32'h3F);
    cmd(pool_pkg::OP_REQUEST, 4'h0, 2'h2, 3'b011);
    rd(`REG_RESULT, 33'h103, 33'hFF0F);
    flag(in_path[3], 1'b0);
    lfsr = step(lfsr);
    delay <= lfsr[7:0];
    cmd(pool_pkg::OP_CONNECT, 4'h3, 2'h0, 3'b000);
    rd(`REG_STATE_LO, 33'h595, 33'hFFF);
    flag(in_path[3], 1'b1);
    drop_dtr <= 12'h008;
    for (n = 0; n < 20 && tx_space[3] !== 1'b1; n++) @(posedge pclk);
    flag(tx_space[3], 1'b1);
    cmd(pool_pkg::OP_INTERCEPT, 4'h3, 2'h0, 3'b000);
    rd(`REG_STATE_LO, 33'h515, 33'hFFF);
    flag(in_path[3], 1'b0);
    drop_dtr <= 12'h000;
    cmd(pool_pkg::OP_QUEUED, 4'h2, 2'h0, 3'b000);
    rd(`REG_STATE_LO, 33'h505, 33'hFFF);
    cmd(pool_pkg::OP_RELEASE, 4'h0, 2'h0, 3'b000);
    rd(`REG_STATE_LO, 33'h504, 33'hFFF);
    apb(1'b1, `REG_CTRL, 32'h2F);
    cmd(pool_pkg::OP_REQUEST, 4'h0, 2'h1, 3'b011);
    rd(`REG_RESULT, 33'h100, 33'hFF0F);
    cmd(pool_pkg::OP_CONNECT, 4'h0, 2'h0, 3'b000);
    loop_req <= 12'h001;
    for (n = 0; n < 20 && dsr[0] !== 1'b1; n++) @(posedge pclk);
    flag(dsr[0], 1'b1);
    drop_dtr <= 12'h001;
    for (n = 0; n < 20 && hangup[0] !== 1'b1; n++) @(posedge pclk);
    flag(hangup[0], 1'b1);
    close_out();
  end
endmodule
